// ---- hw/mri_regs.vh ----
// register offsets, reset values and timing counts of the reset and init block
`ifndef MRI_REGS_VH
`define MRI_REGS_VH
`define MRI_SP_RESET       8'h6f
`define MRI_INT_VECTOR     15'h00ff
`define MRI_RAM_TOP        8'h6f
`define MRI_REG_BASE       8'hf0
`define MRI_ADDR_ALT_PTR   8'hfc
`define MRI_ADDR_STACK_PTR 8'hfd
`define MRI_ADDR_PRI_PTR   8'hfe
`define MRI_ADDR_RSVD      8'hff
`define MRI_ADDR_TIMER1SER 8'hee
`define MRI_ADDR_PSW       8'hef
`define MRI_ADDR_INTCTRL   8'he8
`define MRI_ADDR_TIMER2    8'hc6
`define MRI_ADDR_SUPV      8'hc7
`define MRI_ADDR_WK_POL    8'hc8
`define MRI_ADDR_WK_EN     8'hc9
`define MRI_ADDR_WK_PEND   8'hca
`define MRI_ADDR_L_DATA    8'hd0
`define MRI_ADDR_L_CONF    8'hd1
`define MRI_ADDR_L_PIN     8'hd2
`define MRI_ADDR_G_DATA    8'hd4
`define MRI_ADDR_G_CONF    8'hd5
`define MRI_ADDR_G_PIN     8'hd6
`define MRI_ADDR_C_DATA    8'hd8
`define MRI_ADDR_C_CONF    8'hd9
`define MRI_ADDR_C_PIN     8'hda
`define MRI_ADDR_D_DATA    8'hdc
`define MRI_D_RESET        8'hff
`define MRI_SUPV_RESET     8'hc1
`define MRI_SUPV_CLKMON    0
`define MRI_G_HALT         7
`define MRI_G_IDLE         6
`define MRI_SEC_SECURED    8'hff
`define MRI_SEC_OPEN       8'h00
`define MRI_TC_DIVIDE      4'd10
`define MRI_FAULT_HOLD_TC  5'd16
`define MRI_WD_WINDOW_TC   65536
`endif

// ---- hw/mri_reset_init.v ----
// core reset init, pointer registers, data memory map, security and tc divider
//
// Behaviour
// - stack pointer loads 6f on reset
// - program counter: 7-bit high, 8-bit low
// - two 8-bit ram pointers with post step
// - cpu registers mapped except accumulator, pc
// - interrupts jump to program address 0ff
// - secured part returns 00 to programmer
// - security byte reads 00 open, ff secured
// - security byte only in programming mode
// - f0 to fe: immediate load, decrement-skip-zero
// - pointers at fc, fd, fe; ff reserved
// - bit set, clear, test; accumulator test
// - reset clears ports l, g, c to hi-z
// - reset drives port d high
// - reset clears pc, psw, timer and interrupt controls, wakeup
// - supervisor armed out of reset, bits set
// - slow clock at reset end: fault low
// - fault ends 16-32 tc after clock ok
// - instruction clock is input divided by ten
// - rc mode: feedback pin input, halt restart
// - rc mode: feedback rising edge leaves halt
`timescale 1ns/1ps
`include "mri_regs.vh"
module mri_reset_init (
  input  wire        core_clk,
  input  wire        rst_b,
  input  wire        rcMode,
  input  wire [7:0]  memAddr,
  input  wire        memRead,
  input  wire        memWrite,
  input  wire [7:0]  memWdata,
  input  wire [1:0]  memBitOp,
  input  wire [2:0]  memBitIdx,
  input  wire        memDsz,
  input  wire        ptrSel,
  input  wire        ptrInc,
  input  wire        ptrDec,
  input  wire [7:0]  accValue,
  input  wire        pcLoad,
  input  wire [14:0] pcValue,
  input  wire        pcStep,
  input  wire        intTake,
  input  wire        progMode,
  input  wire        progRead,
  input  wire        progSecSel,
  input  wire [7:0]  progMemData,
  input  wire        secProgrammed,
  input  wire [7:0]  lPins,
  input  wire [7:0]  gPins,
  input  wire [7:0]  cPins,
  input  wire        oscFeedbackIn,
  input  wire        clkFreqOk,
  output reg  [7:0]  memRdata,
  output reg         bitTestResult,
  output reg         accBitResult,
  output reg         skipZero,
  output reg  [6:0]  programCounterHigh,
  output reg  [7:0]  programCounterLow,
  output reg  [7:0]  progRdata,
  output reg  [7:0]  portLOut,
  output reg  [7:0]  portLOe,
  output reg  [7:0]  portGOut,
  output reg  [7:0]  portGOe,
  output reg  [7:0]  portCOut,
  output reg  [7:0]  portCOe,
  output reg  [7:0]  portDOut,
  output reg         faultOut,
  output reg         faultOe,
  output reg         haltMode,
  output reg         idleMode,
  output reg         tcTick
);
  localparam BIT_SET   = 2'b01;
  localparam BIT_CLEAR = 2'b10;
  localparam BIT_TEST  = 2'b11;
  localparam MON_IDLE  = 2'd0;
  localparam MON_FAULT = 2'd1;
  localparam MON_HOLD  = 2'd2;
  localparam MON_DONE  = 2'd3;
  localparam [14:0] INT_VEC = `MRI_INT_VECTOR;

  reg        rstMeta;
  reg        rstSync;
  reg [3:0]  tcCount;
  reg [7:0]  ram [0:111];
  reg [7:0]  regFile [0:15];
  reg [7:0]  stackPointer;
  reg [7:0]  primaryPointer;
  reg [7:0]  alternatePointer;
  reg [7:0]  processorStatusWord;
  reg [7:0]  timer1SerialControl;
  reg [7:0]  interruptControlWord;
  reg [7:0]  timer2ControlWord;
  reg [7:0]  wakeupEnableReg;
  reg [7:0]  wakeupPolarityReg;
  reg [7:0]  wakeupPendingReg;
  reg [7:0]  supervisorControl;
  reg [7:0]  gConfig;
  reg [25:0] pinS1;
  reg [25:0] pinS2;
  reg [25:0] pinS3;
  reg [25:0] pinStable;
  reg        fbPrev;
  reg [1:0]  monState;
  reg [4:0]  monCount;
  reg [7:0]  curByte;
  reg [7:0]  next_byte;
  reg        doWrite;
  wire       touch = memWrite | (memBitOp == BIT_SET) | (memBitOp == BIT_CLEAR) | memDsz;
  wire       clkOkSync = pinStable[25];
  wire       fbSync    = pinStable[24];
  wire       inRegs    = (memAddr[7:4] == 4'hf);

  // two-stage reset release
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // divide by ten into one-cycle tc enable
  always @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      tcCount <= 4'd0;
      tcTick  <= 1'b0;
    end else if (tcCount == `MRI_TC_DIVIDE - 4'd1) begin
      tcCount <= 4'd0;
      tcTick  <= 1'b1;
    end else begin
      tcCount <= tcCount + 4'd1;
      tcTick  <= 1'b0;
    end
  end

  // three-flop pin sampling, taken when stages two and three agree
  // runs through reset so the clock status is settled when reset ends
  always @(posedge core_clk) begin
    pinS1     <= {clkFreqOk, oscFeedbackIn, cPins, gPins, lPins};
    pinS2     <= pinS1;
    pinS3     <= pinS2;
    pinStable <= (pinS2 & ~(pinS2 ^ pinS3)) | (pinStable & (pinS2 ^ pinS3));
  end

  // data memory read mux
  always @* begin
    curByte = 8'h00;
    if (memAddr <= `MRI_RAM_TOP)
      curByte = ram[memAddr[6:0]];
    else if (memAddr == `MRI_ADDR_ALT_PTR)
      curByte = alternatePointer;
    else if (memAddr == `MRI_ADDR_STACK_PTR)
      curByte = stackPointer;
    else if (memAddr == `MRI_ADDR_PRI_PTR)
      curByte = primaryPointer;
    else if (memAddr == `MRI_ADDR_RSVD)
      curByte = 8'h00;
    else if (inRegs)
      curByte = regFile[memAddr[3:0]];
    else if (memAddr == `MRI_ADDR_PSW)
      curByte = processorStatusWord;
    else if (memAddr == `MRI_ADDR_TIMER1SER)
      curByte = timer1SerialControl;
    else if (memAddr == `MRI_ADDR_INTCTRL)
      curByte = interruptControlWord;
    else if (memAddr == `MRI_ADDR_TIMER2)
      curByte = timer2ControlWord;
    else if (memAddr == `MRI_ADDR_SUPV)
      curByte = supervisorControl;
    else if (memAddr == `MRI_ADDR_WK_POL)
      curByte = wakeupPolarityReg;
    else if (memAddr == `MRI_ADDR_WK_EN)
      curByte = wakeupEnableReg;
    else if (memAddr == `MRI_ADDR_WK_PEND)
      curByte = wakeupPendingReg;
    else if (memAddr == `MRI_ADDR_L_DATA)
      curByte = portLOut;
    else if (memAddr == `MRI_ADDR_L_CONF)
      curByte = portLOe;
    else if (memAddr == `MRI_ADDR_L_PIN)
      curByte = pinStable[7:0];
    else if (memAddr == `MRI_ADDR_G_DATA)
      curByte = {2'b00, portGOut[5:0]}; // halt and idle bits read zero
    else if (memAddr == `MRI_ADDR_G_CONF)
      curByte = gConfig;
    else if (memAddr == `MRI_ADDR_G_PIN)
      curByte = {(rcMode & fbSync), pinStable[14:8]};
    else if (memAddr == `MRI_ADDR_C_DATA)
      curByte = portCOut;
    else if (memAddr == `MRI_ADDR_C_CONF)
      curByte = portCOe;
    else if (memAddr == `MRI_ADDR_C_PIN)
      curByte = pinStable[23:16];
    else if (memAddr == `MRI_ADDR_D_DATA)
      curByte = portDOut;
  end

  // new value for write, bit set/clear or register decrement
  always @* begin
    next_byte = curByte;
    doWrite   = touch;
    if (memWrite)
      next_byte = memWdata;
    else if (memBitOp == BIT_SET)
      next_byte = curByte | (8'h01 << memBitIdx);
    else if (memBitOp == BIT_CLEAR)
      next_byte = curByte & ~(8'h01 << memBitIdx);
    else if (memDsz && inRegs)
      next_byte = curByte - 8'h01;
    else
      doWrite = 1'b0;
  end

  // mapped registers, pointers and port control
  always @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      stackPointer         <= `MRI_SP_RESET;
      primaryPointer       <= 8'h00;
      alternatePointer     <= 8'h00;
      processorStatusWord  <= 8'h00;
      timer1SerialControl  <= 8'h00;
      interruptControlWord <= 8'h00;
      timer2ControlWord    <= 8'h00;
      wakeupEnableReg      <= 8'h00;
      wakeupPolarityReg    <= 8'h00;
      wakeupPendingReg     <= 8'h00;
      supervisorControl    <= `MRI_SUPV_RESET;
      portLOut             <= 8'h00;
      portLOe              <= 8'h00;
      portGOut             <= 8'h00;
      portGOe              <= 8'h00;
      gConfig              <= 8'h00;
      portCOut             <= 8'h00;
      portCOe              <= 8'h00;
      portDOut             <= `MRI_D_RESET;
      haltMode             <= 1'b0;
      idleMode             <= 1'b0;
      memRdata             <= 8'h00;
      bitTestResult        <= 1'b0;
      accBitResult         <= 1'b0;
      skipZero             <= 1'b0;
      fbPrev               <= 1'b0;
    end else begin
      memRdata      <= memRead ? curByte : memRdata;
      bitTestResult <= (memBitOp == BIT_TEST) ? curByte[memBitIdx] : bitTestResult;
      accBitResult  <= accValue[memBitIdx];
      skipZero      <= memDsz && inRegs && !memWrite && (memBitOp == 2'b00)
                       && (next_byte == 8'h00);
      fbPrev        <= fbSync;
      // post step of the selected pointer
      if (ptrInc ^ ptrDec) begin
        if (ptrSel)
          alternatePointer <= ptrInc ? alternatePointer + 8'h01 : alternatePointer - 8'h01;
        else
          primaryPointer <= ptrInc ? primaryPointer + 8'h01 : primaryPointer - 8'h01;
      end
      if (rcMode && haltMode && fbSync && !fbPrev)
        haltMode <= 1'b0;
      if (doWrite) begin
        if (memAddr == `MRI_ADDR_ALT_PTR)
          alternatePointer <= next_byte;
        else if (memAddr == `MRI_ADDR_STACK_PTR)
          stackPointer <= next_byte;
        else if (memAddr == `MRI_ADDR_PRI_PTR)
          primaryPointer <= next_byte;
        else if (memAddr == `MRI_ADDR_PSW)
          processorStatusWord <= next_byte;
        else if (memAddr == `MRI_ADDR_TIMER1SER)
          timer1SerialControl <= next_byte;
        else if (memAddr == `MRI_ADDR_INTCTRL)
          interruptControlWord <= next_byte;
        else if (memAddr == `MRI_ADDR_TIMER2)
          timer2ControlWord <= next_byte;
        else if (memAddr == `MRI_ADDR_SUPV)
          supervisorControl <= next_byte;
        else if (memAddr == `MRI_ADDR_WK_POL)
          wakeupPolarityReg <= next_byte;
        else if (memAddr == `MRI_ADDR_WK_EN)
          wakeupEnableReg <= next_byte;
        else if (memAddr == `MRI_ADDR_WK_PEND)
          wakeupPendingReg <= next_byte;
        else if (memAddr == `MRI_ADDR_L_DATA)
          portLOut <= next_byte;
        else if (memAddr == `MRI_ADDR_L_CONF)
          portLOe <= next_byte;
        else if (memAddr == `MRI_ADDR_G_DATA) begin
          portGOut <= {2'b00, next_byte[5:2], 1'b0, next_byte[0]}; // g1 is the fault pin
          haltMode <= next_byte[`MRI_G_HALT];
          idleMode <= next_byte[`MRI_G_IDLE];
        end else if (memAddr == `MRI_ADDR_G_CONF) begin
          gConfig <= next_byte;
          portGOe <= {2'b00, next_byte[5:2], 1'b0, next_byte[0]};
        end else if (memAddr == `MRI_ADDR_C_DATA)
          portCOut <= next_byte;
        else if (memAddr == `MRI_ADDR_C_CONF)
          portCOe <= next_byte;
        else if (memAddr == `MRI_ADDR_D_DATA)
          portDOut <= next_byte;
      end
    end
  end

  // plain ram and general registers, no reset
  always @(posedge core_clk) begin
    if (doWrite && memAddr <= `MRI_RAM_TOP)
      ram[memAddr[6:0]] <= next_byte;
    else if (doWrite && inRegs && memAddr < `MRI_ADDR_ALT_PTR)
      regFile[memAddr[3:0]] <= next_byte;
  end

  // program counter
  always @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      programCounterHigh <= 7'h00;
      programCounterLow  <= 8'h00;
    end else if (intTake) begin
      programCounterHigh <= INT_VEC[14:8];
      programCounterLow  <= INT_VEC[7:0];
    end else if (pcLoad) begin
      programCounterHigh <= pcValue[14:8];
      programCounterLow  <= pcValue[7:0];
    end else if (pcStep) begin
      {programCounterHigh, programCounterLow} <= {programCounterHigh, programCounterLow} + 15'd1;
    end
  end

  // programmer reads with security
  always @(posedge core_clk or negedge rstSync) begin
    if (!rstSync)
      progRdata <= 8'h00;
    else if (progRead && progMode && progSecSel)
      progRdata <= secProgrammed ? `MRI_SEC_SECURED : `MRI_SEC_OPEN;
    else if (progRead && progMode)
      progRdata <= secProgrammed ? 8'h00 : progMemData;
    else if (progRead)
      progRdata <= 8'h00;
  end

  // clock monitor and fault pin
  always @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      monState <= MON_IDLE;
      monCount <= 5'd0;
      faultOut <= 1'b0;
      faultOe  <= 1'b0;
    end else begin
      case (monState)
        MON_IDLE: begin
          if (supervisorControl[`MRI_SUPV_CLKMON] && !clkOkSync) begin
            monState <= MON_FAULT;
            faultOe  <= 1'b1;
          end else
            monState <= MON_DONE;
        end
        MON_FAULT: begin
          monCount <= 5'd0;
          if (clkOkSync)
            monState <= MON_HOLD;
        end
        MON_HOLD: begin
          if (!clkOkSync) begin
            monState <= MON_FAULT;
          end else if (tcTick) begin
            monCount <= monCount + 5'd1;
            if (monCount == `MRI_FAULT_HOLD_TC - 5'd1) begin
              faultOe  <= 1'b0;
              monState <= MON_DONE;
            end
          end
        end
        default: monState <= MON_DONE;
      endcase
    end
  end
endmodule // mri_reset_init

// ---- sim/mri_reset_init_assertions.sv ----
// assertion checker for the reset and init block
`timescale 1ns/1ps
module mri_reset_init_assertions (
  input wire logic       core_clk,
  input wire logic       rst_b,
  input wire logic       clkFreqOk,
  input wire logic       intTake,
  input wire logic       progMode,
  input wire logic       progRead,
  input wire logic       progSecSel,
  input wire logic       secProgrammed,
  input wire logic [7:0] progRdata,
  input wire logic [6:0] programCounterHigh,
  input wire logic [7:0] programCounterLow,
  input wire logic [7:0] portDOut,
  input wire logic [7:0] portLOe,
  input wire logic       faultOut,
  input wire logic       faultOe,
  input wire logic       tcTick
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic [5:0] okTicks;
  // tc ticks since the clock was last seen slow, held at 63
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) okTicks <= 6'h00;
    else if (!clkFreqOk) okTicks <= 6'h00;
    else if (tcTick && okTicks != 6'h3f) okTicks <= okTicks + 6'h01;
  end
  // reset look of the outputs, and a slow clock at release
  sequence resetLook;
    {programCounterHigh, programCounterLow} == 15'h0000 && portDOut == 8'hff && portLOe == 8'h00;
  endsequence
  sequence slowRelease;
    $rose(rst_b) && !clkFreqOk ##1 !clkFreqOk [*5];
  endsequence
  a_reset_outputs: assert property ($rose(rst_b) |-> resetLook ##1 resetLook)
    else $error("reset values lost");
  a_fault_raise: assert property (slowRelease |-> faultOe && !faultOut)
    else $error("no fault on slow clock");
  a_fault_hold: assert property ($fell(faultOe) |-> okTicks >= 6'd16)
    else $error("fault ended early");
  a_int_vector: assert property (intTake |=> {programCounterHigh, programCounterLow} == 15'h00ff)
    else $error("bad vector");
  a_tc_period: assert property (tcTick |=> !tcTick [*8] ##1 !tcTick ##1 tcTick)
    else $error("tc period wrong");
  a_sec_byte: assert property (progRead && progMode && progSecSel
    |=> progRdata == ($past(secProgrammed) ? 8'hff : 8'h00)) else $error("bad security byte");
  a_secured_array: assert property (progRead && progMode && !progSecSel && secProgrammed
    |=> progRdata == 8'h00) else $error("secured data leaked");
  a_sec_hidden: assert property (progRead && !progMode |=> progRdata == 8'h00)
    else $error("read outside programming");
endmodule // mri_reset_init_assertions

bind mri_reset_init mri_reset_init_assertions chk (.core_clk(core_clk), .rst_b(rst_b),
  .clkFreqOk(clkFreqOk), .intTake(intTake), .progMode(progMode), .progRead(progRead),
  .progSecSel(progSecSel), .secProgrammed(secProgrammed), .progRdata(progRdata),
  .programCounterHigh(programCounterHigh), .programCounterLow(programCounterLow),
  .portDOut(portDOut), .portLOe(portLOe), .faultOut(faultOut), .faultOe(faultOe), .tcTick(tcTick));

// ---- sim/mri_reset_init_tb.sv ----
// random and corner tests of the reset and init block
`timescale 1ns/1ps
module mri_reset_init_tb;
  localparam logic [4:0] RD = 5'h10, WR = 5'h08, SET = 5'h02, CLR = 5'h04, TST = 5'h06;
  localparam logic [4:0] DSZ = 5'h01;
  logic        core_clk = 1'b0, rst_b = 1'b0, rcMode = 1'b0, memRead = 1'b0, memWrite = 1'b0;
  logic        memDsz = 1'b0, ptrSel = 1'b0, ptrInc = 1'b0, ptrDec = 1'b0, pcLoad = 1'b0;
  logic        pcStep = 1'b0, intTake = 1'b0, progMode = 1'b0, progRead = 1'b0;
  logic        progSecSel = 1'b0, secProgrammed = 1'b0, oscFeedbackIn = 1'b0, clkFreqOk = 1'b1;
  logic [1:0]  memBitOp = 2'h0;
  logic [2:0]  memBitIdx = 3'h0;
  logic [7:0]  memAddr = 8'h00, memWdata = 8'h00, accValue = 8'h00, progMemData = 8'h00;
  logic [14:0] pcValue = 15'h0000;
  logic [7:0]  memRdata, progRdata, programCounterLow, portLOut, portLOe, portGOut, portGOe;
  logic [7:0]  portCOut, portCOe, portDOut;
  logic [6:0]  programCounterHigh;
  logic        bitTestResult, accBitResult, skipZero, faultOut, faultOe, haltMode, idleMode;
  logic        tcTick;
  logic [15:0] seed = 16'd30265;
  logic [7:0]  regVal [0:14];
  int          errTotal = 0, nTests = 0, k, t;
  localparam logic [7:0] ZADDR [0:12] = '{8'hef, 8'hee, 8'he8, 8'hc6, 8'hc8, 8'hc9, 8'hca,
    8'hd0, 8'hd1, 8'hd4, 8'hd5, 8'hd8, 8'hd9};

  // design under test, port pins held quiet
  mri_reset_init DUT (.core_clk(core_clk), .rst_b(rst_b), .rcMode(rcMode), .memAddr(memAddr),
    .memRead(memRead), .memWrite(memWrite), .memWdata(memWdata), .memBitOp(memBitOp),
    .memBitIdx(memBitIdx), .memDsz(memDsz), .ptrSel(ptrSel), .ptrInc(ptrInc), .ptrDec(ptrDec),
    .accValue(accValue), .pcLoad(pcLoad), .pcValue(pcValue), .pcStep(pcStep), .intTake(intTake),
    .progMode(progMode), .progRead(progRead), .progSecSel(progSecSel),
    .progMemData(progMemData), .secProgrammed(secProgrammed), .lPins(8'h00), .gPins(8'h00),
    .cPins(8'h00), .oscFeedbackIn(oscFeedbackIn), .clkFreqOk(clkFreqOk), .memRdata(memRdata),
    .bitTestResult(bitTestResult), .accBitResult(accBitResult), .skipZero(skipZero),
    .programCounterHigh(programCounterHigh), .programCounterLow(programCounterLow),
    .progRdata(progRdata), .portLOut(portLOut), .portLOe(portLOe), .portGOut(portGOut),
    .portGOe(portGOe), .portCOut(portCOut), .portCOe(portCOe), .portDOut(portDOut),
    .faultOut(faultOut), .faultOe(faultOe), .haltMode(haltMode), .idleMode(idleMode),
    .tcTick(tcTick));

  // 50 ns clock
  always #25 core_clk = ~core_clk;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // programmer read result from {mode, secured, select}
  function automatic logic [7:0] expProg(input logic [2:0] m, input logic [7:0] d);
    if (!m[2]) return 8'h00;
    if (m[0]) return m[1] ? 8'hff : 8'h00;
    return m[1] ? 8'h00 : d;
  endfunction
  task cmp(input string nm, input logic [23:0] ex, got);
    nTests++;
    if (got !== ex) begin
      errTotal++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task reportAndStop;
    $display("compares %0d mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task limit(input logic hit);
    if (hit) begin
      errTotal++;
      reportAndStop;
    end
  endtask
  // one data memory request held for one edge, answer sampled settled
  task op(input logic [7:0] a, input logic [4:0] kind, input logic [7:0] d, input logic [2:0] i);
    @(posedge core_clk);
    {memAddr, memRead, memWrite, memBitOp, memDsz, memWdata, memBitIdx} <= {a, kind, d, i};
    @(posedge core_clk);
    {memRead, memWrite, memBitOp, memDsz} <= 5'h00;
    #1;
  endtask
  task rd(input logic [7:0] a, ex, input string nm);
    op(a, RD, 8'h00, 3'd0);
    cmp(nm, 24'(ex), 24'(memRdata));
  endtask
  task waitTick(output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      #1 n++;
    end while (tcTick !== 1'b1 && n < 40);
    limit(n >= 40);
  endtask

  // main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    rd(8'hfd, 8'h6f, "stack");
    rd(8'hc7, 8'hc1, "supervisor");
    for (k = 0; k < 13; k++) rd(ZADDR[k], 8'h00, "cleared");
    cmp("portD", 24'hff, 24'(portDOut));
    cmp("portOe", 24'h0, {portLOe, portGOe, portCOe});
    cmp("portOut", 24'h0, {portLOut, portGOut, portCOut});
    cmp("pc", 24'h0, 24'({programCounterHigh, programCounterLow}));
    cmp("faultIdle", 24'h0, 24'(faultOe));
    $display("test reset done");
    for (k = 0; k < 15; k++) begin
      seed = lfsr(seed);
      regVal[k] = seed[7:0];
      op(8'hf0 + 8'(k), WR, seed[7:0], 3'd0);
    end
    for (k = 0; k < 15; k++) rd(8'hf0 + 8'(k), regVal[k], "register");
    @(posedge core_clk);
    {ptrSel, ptrInc} <= 2'b01;
    @(posedge core_clk);
    {ptrSel, ptrInc, ptrDec} <= 3'b101;
    @(posedge core_clk);
    ptrDec <= 1'b0;
    rd(8'hfe, regVal[14] + 8'h01, "primaryStep");
    rd(8'hfc, regVal[12] - 8'h01, "altStep");
    op(8'hf1, WR, 8'h01, 3'd0);
    op(8'hf1, DSZ, 8'h00, 3'd0);
    cmp("skipZero", 24'h1, 24'(skipZero));
    rd(8'hf1, 8'h00, "dszValue");
    op(8'hf2, WR, 8'h00, 3'd0);
    op(8'hf2, SET, 8'h00, seed[2:0]);
    rd(8'hf2, 8'h01 << seed[2:0], "bitSet");
    op(8'hf2, TST, 8'h00, seed[2:0]);
    cmp("bitTest", 24'h1, 24'(bitTestResult));
    op(8'hf2, CLR, 8'h00, seed[2:0]);
    rd(8'hf2, 8'h00, "bitClear");
    @(posedge core_clk);
    {accValue, memBitIdx} <= {seed[15:8], seed[5:3]};
    @(posedge core_clk);
    #1 cmp("accBit", 24'(seed[8 + seed[5:3]]), 24'(accBitResult));
    $display("test memory done");
    seed = lfsr(seed);
    @(posedge core_clk);
    {pcLoad, pcValue} <= {1'b1, seed[14:0]};
    @(posedge core_clk);
    {pcLoad, pcStep} <= 2'b01;
    @(posedge core_clk);
    {pcStep, intTake} <= 2'b01;
    #1 cmp("pcStep", 24'(seed[14:0] + 15'h1), 24'({programCounterHigh, programCounterLow}));
    @(posedge core_clk);
    intTake <= 1'b0;
    #1 cmp("vector", 24'hff, 24'({programCounterHigh, programCounterLow}));
    for (k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      @(posedge core_clk);
      {progMode, secProgrammed, progSecSel, progRead, progMemData} <= {3'(k), 1'b1, seed[7:0]};
      @(posedge core_clk);
      progRead <= 1'b0;
      #1 cmp("progRead", 24'(expProg(3'(k), seed[7:0])), 24'(progRdata));
    end
    $display("test pc and security done");
    waitTick(t);
    waitTick(t);
    cmp("tcSpacing", 24'd10, 24'(t));
    @(posedge core_clk);
    rcMode <= 1'b1;
    op(8'hd4, WR, 8'hc0, 3'd0);
    repeat (2) @(posedge core_clk);
    #1 cmp("haltIdle", 24'h3, 24'({haltMode, idleMode}));
    @(posedge core_clk);
    oscFeedbackIn <= 1'b1;
    for (k = 0; k < 10 && haltMode === 1'b1; k++) @(posedge core_clk) #1;
    limit(k == 10);
    $display("test tc and halt done");
    @(posedge core_clk);
    {rst_b, clkFreqOk, rcMode} <= 3'b000;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (10) @(posedge core_clk);
    #1 cmp("faultLow", 24'h2, 24'({faultOe, faultOut}));
    @(posedge core_clk);
    clkFreqOk <= 1'b1;
    t = 0;
    for (k = 0; k < 800 && faultOe === 1'b1; k++) begin
      @(posedge core_clk);
      #1 t += int'(tcTick);
    end
    limit(k == 800);
    cmp("faultTicks", 24'h1, 24'(t >= 16 && t <= 32));
    $display("test fault done");
    reportAndStop;
  end
endmodule // mri_reset_init_tb
